// file: include/pie_defines.svh
`ifndef PIE_DEFINES_SVH
`define PIE_DEFINES_SVH

// Register byte addresses
`define PIE_ADDR_ENABLE    8'h00
`define PIE_ADDR_CONTROL   8'h04
`define PIE_ADDR_FLAGS     8'h08
`define PIE_ADDR_STATUS    8'h0c
`define PIE_ADDR_MASK      8'h10
`define PIE_ADDR_REQUEST   8'h14

// Enable register bit positions
`define PIE_BIT_CONVERTER  6
`define PIE_BIT_CAPCMP     5
`define PIE_BIT_COMP_B     4
`define PIE_BIT_COMP_A     3
`define PIE_BIT_PERIOD     1
`define PIE_BIT_OVERFLOW   0

// Control register bit positions
`define PIE_BIT_GLOBAL     7
`define PIE_BIT_GROUP      6

// Writable masks
`define PIE_MASK_FULL      8'h7b
`define PIE_MASK_REDUCED   8'h19
`define PIE_MASK_CONTROL   8'hc0

// Reset values
`define PIE_RST_ENABLE     8'h00
`define PIE_RST_CONTROL    8'h00
`define PIE_RST_STATUS     2'h0
`define PIE_RST_MASK       2'h0

`endif

// file: include/pie_pkg.sv
package pie_pkg;
    typedef logic [7:0] pie_byte_t;
    typedef enum logic [0:0] {
        PIE_IDLE = 1'b0,
        PIE_ACK  = 1'b1
    } pie_bus_state_t;
endpackage

// file: verilog/pie_sync.sv
`timescale 1ns/1ns
module pie_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    // Data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage_a;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            stage_a <= '0;
            sync_o  <= '0;
        end else begin
            stage_a <= async_i;
            sync_o  <= stage_a;
        end
    end
endmodule

// file: verilog/pie_top.sv
`timescale 1ns/1ns
`include "pie_defines.svh"
// Operation
// [R1] Peripheral requests blocked unless peripheral-group enable is set.
// [R2] Bit 6 enables the converter-complete interrupt.
// [R3] Bit 5 enables the capture/compare/PWM interrupt.
// [R4] Bit 4 enables the second comparator interrupt.
// [R5] Bit 3 enables the first comparator interrupt.
// [R6] Bit 1 enables the period-match timer interrupt.
// [R7] Bit 0 enables the first timer overflow interrupt.
// [R8] Reduced variant: bits 6, 5 and 1 absent, read zero.
// [R9] No request recognized unless the global enable is set.
// [R10] Bits 7 and 2 read zero, ignore writes; enables reset to zero.
// [R11] Request asserted when flag, its enable, group and global enables all set.
module pie_top #(
    parameter bit REDUCED = 1'b0
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Peripheral flags from other clock domains
    input  wire logic [7:0]  periph_flag_i,
    // Interrupt outputs
    output logic             periph_irq_o,
    output logic             irq_o
);
    // ************************************************
    // Declarations
    // ************************************************
    pie_pkg::pie_byte_t       peripheral_irq_enable_1;
    pie_pkg::pie_byte_t       interrupt_control_reg;
    pie_pkg::pie_byte_t       flag_sync;
    pie_pkg::pie_byte_t       impl_mask;
    pie_pkg::pie_byte_t       gated;
    pie_pkg::pie_bus_state_t  bus_state;
    logic [1:0]               irq_status;
    logic [1:0]               irq_mask;
    logic [1:0]               irq_event;
    logic                     next_request;
    logic                     request_q;
    logic                     global_irq_enable;
    logic                     peripheral_group_enable;
    logic                     access;
    logic                     wr_lane0;
    logic                     hit;
    logic [31:0]              next_rdata;

    // ************************************************
    // Flag synchroniser
    // ************************************************
    pie_sync #(
        .WIDTH (8)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    (periph_flag_i),
        .sync_o     (flag_sync)
    );

    // ************************************************
    // Request gating
    // ************************************************
    assign impl_mask = REDUCED ? `PIE_MASK_REDUCED : `PIE_MASK_FULL; // [R8] [R10]
    assign global_irq_enable       = interrupt_control_reg[`PIE_BIT_GLOBAL];
    assign peripheral_group_enable = interrupt_control_reg[`PIE_BIT_GROUP];
    // Bits 6,5,4,3,1,0 each gate their own flag [R2] [R3] [R4] [R5] [R6] [R7]
    assign gated = flag_sync & peripheral_irq_enable_1 & impl_mask;

    always_comb begin
        next_request = 1'b0;
        if (global_irq_enable && peripheral_group_enable) begin // [R1] [R9]
            next_request = |gated; // [R11]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            request_q <= 1'b0;
        end else begin
            request_q <= next_request;
        end
    end
    assign periph_irq_o = request_q;

    // ************************************************
    // Bus handshake
    // ************************************************
    assign access   = wb_cyc_i && wb_stb_i && (bus_state == pie_pkg::PIE_IDLE);
    assign wr_lane0 = access && wb_we_i && wb_sel_i[0];

    always_comb begin
        hit = 1'b1;
        if (wb_adr_i == `PIE_ADDR_ENABLE) begin
            next_rdata = {24'h000000, peripheral_irq_enable_1};
        end else if (wb_adr_i == `PIE_ADDR_CONTROL) begin
            next_rdata = {24'h000000, interrupt_control_reg};
        end else if (wb_adr_i == `PIE_ADDR_FLAGS) begin
            next_rdata = {24'h000000, flag_sync & impl_mask};
        end else if (wb_adr_i == `PIE_ADDR_STATUS) begin
            next_rdata = {30'h0, irq_status};
        end else if (wb_adr_i == `PIE_ADDR_MASK) begin
            next_rdata = {30'h0, irq_mask};
        end else if (wb_adr_i == `PIE_ADDR_REQUEST) begin
            next_rdata = {31'h0, request_q};
        end else begin
            hit        = 1'b0;
            next_rdata = 32'h00000000;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            bus_state <= pie_pkg::PIE_IDLE;
            wb_ack_o  <= 1'b0;
            wb_err_o  <= 1'b0;
            wb_dat_o  <= 32'h00000000;
        end else begin
            case (bus_state)
                pie_pkg::PIE_IDLE: begin
                    if (access) begin
                        bus_state <= pie_pkg::PIE_ACK;
                        wb_ack_o  <= hit;
                        wb_err_o  <= !hit;
                        wb_dat_o  <= wb_we_i ? 32'h00000000 : next_rdata;
                    end
                end
                default: begin
                    bus_state <= pie_pkg::PIE_IDLE;
                    wb_ack_o  <= 1'b0;
                    wb_err_o  <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************
    // Enable and control registers
    // ************************************************
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            peripheral_irq_enable_1 <= `PIE_RST_ENABLE; // [R10]
        end else if (wr_lane0 && wb_adr_i == `PIE_ADDR_ENABLE) begin
            peripheral_irq_enable_1 <= wb_dat_i[7:0] & impl_mask; // [R8] [R10]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            interrupt_control_reg <= `PIE_RST_CONTROL;
        end else if (wr_lane0 && wb_adr_i == `PIE_ADDR_CONTROL) begin
            interrupt_control_reg <= wb_dat_i[7:0] & `PIE_MASK_CONTROL;
        end
    end

    // ************************************************
    // Sticky status and mask
    // ************************************************
    // Bit 0: request rises, bit 1: request falls
    assign irq_event = {request_q & ~next_request, ~request_q & next_request};

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_status <= `PIE_RST_STATUS;
        end else if (wr_lane0 && wb_adr_i == `PIE_ADDR_STATUS) begin
            // Set wins over write-one-to-clear
            irq_status <= (irq_status & ~wb_dat_i[1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_mask <= `PIE_RST_MASK;
        end else if (wr_lane0 && wb_adr_i == `PIE_ADDR_MASK) begin
            irq_mask <= wb_dat_i[1:0];
        end
    end

    assign irq_o = |(irq_status & irq_mask);
endmodule

// file: bench/pie_top_checker.sv
`timescale 1ns/1ns
`include "pie_defines.svh"
module pie_top_checker #(parameter bit REDUCED = 1'b0) (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic [7:0]  periph_flag_i,
    input wire logic        periph_irq_o
);
    localparam logic [7:0] IMPL = REDUCED ? `PIE_MASK_REDUCED : `PIE_MASK_FULL;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_en_read;
        s_take ##0 (!wb_we_i && wb_adr_i == `PIE_ADDR_ENABLE);
    endsequence
    a_answer_next: assert property (s_take |=> wb_ack_o != wb_err_o) else $error("no single answer");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_err_pulse: assert property (wb_err_o |=> !wb_err_o) else $error("err too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
    a_enable_unimpl: assert property (s_en_read |=> (wb_dat_o[7:0] & ~IMPL) == 8'h00)
        else $error("absent enable bit reads one");
    a_request_cause: assert property (periph_irq_o |-> $past(periph_flag_i, 3) != 8'h00)
        else $error("request without flag");
    a_request_drop: assert property ((periph_flag_i == 8'h00) [*3] |=> !periph_irq_o)
        else $error("request stays without flag");
endmodule
bind pie_top pie_top_checker #(.REDUCED(REDUCED)) u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .periph_flag_i(periph_flag_i), .periph_irq_o(periph_irq_o));

// file: bench/test_peripheral_interrupt_enable.sv
`timescale 1ns/1ns
`include "pie_defines.svh"
module test_peripheral_interrupt_enable;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, ack, err, pirq, irq, e;
    logic [7:0]  adr = 8'h00, dat = 8'h00, flags = 8'h00;
    logic [31:0] dat_o, q, dat_r, qr;
    logic        pirq_r;
    int          n_mismatch = 0, checks_done = 0, cycles = 0;
    pie_top DUT (.core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i({24'h0, dat}), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .wb_err_o(err), .periph_flag_i(flags), .periph_irq_o(pirq), .irq_o(irq));
    // Reduced variant shares the bus and answers in step with DUT
    pie_top #(.REDUCED(1'b1)) DUT_REDUCED (.core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i({24'h0, dat}), .wb_dat_o(dat_r),
        .wb_ack_o(), .wb_err_o(), .periph_flag_i(flags), .periph_irq_o(pirq_r), .irq_o());
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
        checks_done++;
        if (got !== x) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, x, got);
        end
    endtask
    // Classic cycle, held until ack or err is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
        q = dat_o;
        qr = dat_r;
        e = err;
        cyc <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
        bus(1'b0, a, 8'h00);
        chk(nm, x, q);
    endtask
    task automatic t_regs;
        rd(`PIE_ADDR_ENABLE, 32'h0, "enable");
        bus(1'b1, `PIE_ADDR_ENABLE, 8'hff);
        rd(`PIE_ADDR_ENABLE, 32'h7b, "enable bits");
        chk("reduced enable bits", 32'h19, qr);
        bus(1'b1, `PIE_ADDR_CONTROL, 8'hff);
        rd(`PIE_ADDR_CONTROL, 32'hc0, "control bits");
        bus(1'b0, 8'h20, 8'h00);
        chk("unmapped", 32'h1, 32'(e));
        $display("t_regs done");
    endtask
    task automatic t_gate;
        int b[6] = '{6, 5, 4, 3, 1, 0};
        for (int k = 0; k < 6; k++) begin
            bus(1'b1, `PIE_ADDR_ENABLE, 8'h01 << b[k]);
            bus(1'b1, `PIE_ADDR_CONTROL, 8'hc0);
            flags <= 8'h7b ^ (8'h01 << b[k]);
            repeat (4) @(posedge clk);
            chk("other", 32'h0, 32'(pirq));
            flags <= 8'h01 << b[k];
            repeat (4) @(posedge clk);
            chk("own", 32'h1, 32'(pirq));
            chk("reduced own", 32'((8'h19 >> b[k]) & 8'h01), 32'(pirq_r));
            bus(1'b1, `PIE_ADDR_CONTROL, 8'h40);
            chk("global", 32'h0, 32'(pirq));
            bus(1'b1, `PIE_ADDR_CONTROL, 8'h80);
            chk("group", 32'h0, 32'(pirq));
        end
        $display("t_gate done");
    endtask
    task automatic t_status;
        bus(1'b1, `PIE_ADDR_STATUS, 8'h03);
        bus(1'b1, `PIE_ADDR_MASK, 8'h01);
        bus(1'b1, `PIE_ADDR_CONTROL, 8'hc0);
        repeat (4) @(posedge clk);
        rd(`PIE_ADDR_STATUS, 32'h1, "rise");
        chk("irq set", 32'h1, 32'(irq));
        rd(`PIE_ADDR_FLAGS, 32'h1, "flags reg");
        rd(`PIE_ADDR_REQUEST, 32'h1, "request reg");
        rd(`PIE_ADDR_MASK, 32'h1, "mask reg");
        bus(1'b1, `PIE_ADDR_STATUS, 8'h01);
        chk("irq clear", 32'h0, 32'(irq));
        flags <= 8'h00;
        repeat (6) @(posedge clk);
        rd(`PIE_ADDR_STATUS, 32'h2, "fall");
        chk("irq masked", 32'h0, 32'(irq));
        $display("t_status done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_gate();
        t_status();
        conclude();
    end
endmodule
